// ### bac_alarm_cfg.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// R01: Gate hysteresis code picks 8/16/32/64 LSBs
// R02: Sense/temp hysteresis code picks 8/16/32/64 LSBs
// R03: Mode 00 clamps until rewrite or clear
// R04: Mode 01 flags alarms, never clamps
// R05: Mode 10 clamps on alarm, releases on a clear sense or temperature result
// R06: Mode 10 gate alarm latches like 11
// R07: Mode 11 alarm clamps, rewrites field 00
// R08: Commands 3Eh write, BEh read source word
// R09: Upper four written bits are ignored
// R10: Bits 11/10 channel 2 gate enable/window
// R11: Bits 9/8 channel 2 temperature enable/window
// R12: Bits 7/6 channel 2 sense enable/window
// R13: Bits 5/4 channel 1 gate enable/window
// R14: Bits 3/2 channel 1 temperature enable/window
// R15: Bits 1/0 channel 1 sense enable/window
// R16: Gate hysteresis at bits 9:8, shared
// R17: Sense/temp hysteresis at bits 7:6, shared
// R18: Channel 2 clamp mode at bits 5:4
// R19: Channel 1 clamp mode at bits 3:2
// R20: Mode write re-evaluates clamp; forced 00 readable

module bac_alarm_cfg #(
  parameter int NUM_CH = 2
) (
  input wire logic clk, // System clock, 40 MHz
  input wire logic rstn, // Asynchronous reset, active low
  input wire bac_pkg::bac_cmd_t cmd, // Decoded command byte with data word
  input wire logic sw_clear, // Software clear of mode-00 clamps
  input wire bac_pkg::bac_conv_t conv, // Conversion result with alarm outcome
  output logic rsp_valid, // One-cycle read answer strobe
  output logic [15:0] rsp_data, // Read answer word
  output logic [11:0] src_cfg, // Live alarm_source_config bits
  output logic [7:0] gate_hyst_lsb, // Gate window hysteresis in LSBs
  output logic [7:0] st_hyst_lsb, // Sense/temp window hysteresis in LSBs
  output logic [NUM_CH-1:0] clamp, // Gate clamp request per channel
  output logic [NUM_CH-1:0] alarm_flag_set // Alarm flag set pulse per channel
);

  if (NUM_CH != 2) begin : g_bad_ch
    $error("bac_alarm_cfg serves exactly two channels");
  end

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Hysteresis width doubles per code step
  function automatic logic [7:0] hyst_lsbs(input logic [1:0] code);
    hyst_lsbs = bac_pkg::HYST_BASE_LSB << code;
  endfunction

  // Enable or window bit of one quantity of one channel
  function automatic logic src_bit(input logic [11:0] cfg, input logic ch,
                                   input bac_pkg::bac_src_t src, input logic win);
    int pos;
    pos = ch ? bac_pkg::SRC_CH_STRIDE : 0;
    case (src)
      bac_pkg::SRC_SENSE: pos = pos + (win ? bac_pkg::SRC_SENSE_WIN : bac_pkg::SRC_SENSE_EN);
      bac_pkg::SRC_TEMP: pos = pos + (win ? bac_pkg::SRC_TEMP_WIN : bac_pkg::SRC_TEMP_EN);
      bac_pkg::SRC_GATE: pos = pos + (win ? bac_pkg::SRC_GATE_WIN : bac_pkg::SRC_GATE_EN);
      default: pos = pos + bac_pkg::SRC_GATE_EN;
    endcase
    src_bit = cfg[pos];
  endfunction

  logic [11:0] out_cfg;
  logic [11:0] next_src_cfg;
  logic [11:0] next_out_cfg;
  logic next_rsp_valid;
  logic [15:0] next_rsp_data;
  logic [7:0] next_gate_hyst;
  logic [7:0] next_st_hyst;
  logic src_wr;
  logic src_rd;
  logic out_wr;
  logic out_rd;
  logic conv_en;
  logic [1:0] mode [NUM_CH];
  logic [11:0] out_view;

  always_comb begin
    src_wr = cmd.valid && cmd.code == bac_pkg::CMD_SRC_WR; // see R08
    src_rd = cmd.valid && cmd.code == bac_pkg::CMD_SRC_RD; // see R08
    out_wr = cmd.valid && cmd.code == bac_pkg::CMD_OUT_WR;
    out_rd = cmd.valid && cmd.code == bac_pkg::CMD_OUT_RD;
  end

  // Disabled checks are dropped before they reach the clamp logic
  always_comb begin
    conv_en = conv.valid && src_bit(src_cfg, conv.ch, conv.src, 1'b0); // see R10 R11 R12 R13 R14 R15
  end

  // Clamp fields live in the channel logic so alarm overwrites read back
  always_comb begin
    out_view = out_cfg;
    out_view[bac_pkg::CLAMP_CH1_POS +: 2] = mode[0]; // see R19 R20
    out_view[bac_pkg::CLAMP_CH2_POS +: 2] = mode[1]; // see R18 R20
  end

  always_comb begin
    next_src_cfg = src_cfg;
    next_out_cfg = out_cfg;
    next_rsp_valid = 1'b0;
    next_rsp_data = rsp_data;
    if (src_wr) begin
      next_src_cfg = cmd.data[11:0]; // see R09
    end
    if (out_wr) begin
      next_out_cfg = cmd.data[11:0];
    end
    if (src_rd) begin
      next_rsp_valid = 1'b1;
      next_rsp_data = {4'h0, src_cfg}; // see R08
    end else if (out_rd) begin
      next_rsp_valid = 1'b1;
      next_rsp_data = {4'h0, out_view};
    end
    next_gate_hyst = hyst_lsbs(out_cfg[bac_pkg::GATE_HYST_POS +: 2]); // see R01 R16
    next_st_hyst = hyst_lsbs(out_cfg[bac_pkg::ST_HYST_POS +: 2]); // see R02 R17
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_cfg <= bac_pkg::SRC_CFG_RST;
      out_cfg <= bac_pkg::OUT_CFG_RST;
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      gate_hyst_lsb <= bac_pkg::HYST_BASE_LSB;
      st_hyst_lsb <= bac_pkg::HYST_BASE_LSB;
    end else begin
      src_cfg <= next_src_cfg;
      out_cfg <= next_out_cfg;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
      gate_hyst_lsb <= next_gate_hyst;
      st_hyst_lsb <= next_st_hyst;
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    localparam int POS = (c == 0) ? bac_pkg::CLAMP_CH1_POS : bac_pkg::CLAMP_CH2_POS;
    bac_clamp_ch u_clamp (
      .clk(clk),
      .rst_n(rst_n),
      .mode_wr(out_wr),
      .mode_wdata(cmd.data[POS +: 2]), // see R18 R19
      .sw_clear(sw_clear),
      .ev_valid(conv_en && conv.ch == 1'(c)),
      .ev_src(conv.src),
      .ev_alarm(conv.alarm),
      .mode(mode[c]),
      .clamp(clamp[c]),
      .flag_set(alarm_flag_set[c])
    );
  end

  chk_src_readback: assert property (@(posedge clk) disable iff (!rst_n) // see R08
    src_rd |=> rsp_valid && rsp_data == {4'h0, $past(src_cfg)})
    else $error("source config read answer wrong");

  chk_upper_ignored: assert property (@(posedge clk) disable iff (!rst_n) // see R09
    src_wr |=> src_cfg == $past(cmd.data[11:0]))
    else $error("written source config not held in low twelve bits");

  chk_gate_hyst: assert property (@(posedge clk) disable iff (!rst_n) // see R01 R16
    out_cfg[9:8] == 2'b11 |=> gate_hyst_lsb == 8'h40)
    else $error("gate hysteresis code 11 not 64 LSBs");

  chk_st_hyst: assert property (@(posedge clk) disable iff (!rst_n) // see R02 R17
    ##1 st_hyst_lsb == (8'h08 << $past(out_cfg[7:6])))
    else $error("sense/temp hysteresis width wrong");

  chk_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see R13 R10
    (conv.valid && conv.src == bac_pkg::SRC_GATE
     && !src_cfg[conv.ch ? 11 : 5]) |=> alarm_flag_set == '0)
    else $error("disabled gate check raised a flag");

  chk_forced_readable: assert property (@(posedge clk) disable iff (!rst_n) // see R20 R07
    (mode[0] == bac_pkg::CLAMP_SEMI && conv_en && !conv.ch && conv.alarm && !out_wr)
    ##1 !out_wr ##1 out_rd |=> rsp_data[3:2] == 2'b00)
    else $error("forced clamp mode not read back as 00");

  chk_rsp_quiet: assert property (@(posedge clk) disable iff (!rst_n) // see R08
    !(src_rd || out_rd) |=> !rsp_valid && $stable(rsp_data))
    else $error("read answer changed without a read command");

  chk_rsp_upper: assert property (@(posedge clk) disable iff (!rst_n) // see R09
    rsp_valid |-> rsp_data[15:12] == 4'h0)
    else $error("read answer upper bits not zero");

  chk_mode_map: assert property (@(posedge clk) disable iff (!rst_n) // see R18 R19
    (out_wr && !conv.valid)
    |=> mode[0] == $past(cmd.data[3:2]) && mode[1] == $past(cmd.data[5:4]))
    else $error("clamp-mode fields not taken from their bit pairs");

  chk_sense_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R12 R15 R04
    (conv.valid && conv.alarm && conv.src == bac_pkg::SRC_SENSE && src_cfg[conv.ch ? 7 : 1])
    |=> alarm_flag_set == ($past(conv.ch) ? 2'b10 : 2'b01))
    else $error("enabled sense alarm did not raise its flag");

  chk_temp_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R11 R14 R04
    (conv.valid && conv.alarm && conv.src == bac_pkg::SRC_TEMP && src_cfg[conv.ch ? 9 : 3])
    |=> alarm_flag_set == ($past(conv.ch) ? 2'b10 : 2'b01))
    else $error("enabled temperature alarm did not raise its flag");

  chk_gate_flag: assert property (@(posedge clk) disable iff (!rst_n) // see R10 R13 R04
    (conv.valid && conv.alarm && conv.src == bac_pkg::SRC_GATE && src_cfg[conv.ch ? 11 : 5])
    |=> alarm_flag_set == ($past(conv.ch) ? 2'b10 : 2'b01))
    else $error("enabled gate alarm did not raise its flag");

endmodule

`default_nettype wire

// ### bac_pkg.sv
package bac_pkg;

  // Command bytes on the serial command port
  localparam logic [7:0] CMD_SRC_WR = 8'h3e;
  localparam logic [7:0] CMD_SRC_RD = 8'hbe;
  localparam logic [7:0] CMD_OUT_WR = 8'h3c;
  localparam logic [7:0] CMD_OUT_RD = 8'hbc;

  // Both configuration words keep only their low twelve bits
  localparam int CFG_W = 12;
  localparam logic [11:0] SRC_CFG_RST = 12'h000;
  localparam logic [11:0] OUT_CFG_RST = 12'h000;

  // alarm_source_config: one six-bit group per channel, channel 1 at the bottom
  localparam int SRC_CH_STRIDE = 6;
  localparam int SRC_SENSE_WIN = 0;
  localparam int SRC_SENSE_EN = 1;
  localparam int SRC_TEMP_WIN = 2;
  localparam int SRC_TEMP_EN = 3;
  localparam int SRC_GATE_WIN = 4;
  localparam int SRC_GATE_EN = 5;

  // alarm_output_config field positions
  localparam int CLAMP_CH1_POS = 2;
  localparam int CLAMP_CH2_POS = 4;
  localparam int ST_HYST_POS = 6;
  localparam int GATE_HYST_POS = 8;

  // Smallest hysteresis step in converter LSBs; codes 0..3 give 8, 16, 32, 64
  localparam logic [7:0] HYST_BASE_LSB = 8'h08;

  typedef enum logic [1:0] {
    CLAMP_FORCE = 2'b00,
    CLAMP_FLAG = 2'b01,
    CLAMP_AUTO = 2'b10,
    CLAMP_SEMI = 2'b11
  } bac_clamp_mode_t;

  typedef enum logic [1:0] {
    SRC_SENSE = 2'b00,
    SRC_TEMP = 2'b01,
    SRC_GATE = 2'b10
  } bac_src_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [15:0] data;
  } bac_cmd_t;

  typedef struct packed {
    logic valid;
    logic ch;
    bac_src_t src;
    logic alarm;
  } bac_conv_t;

endpackage

// ### bac_clamp_ch.sv
`timescale 1ns/1ps
`default_nettype none

module bac_clamp_ch (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  input wire logic mode_wr, // Host writes the clamp-mode field
  input wire logic [1:0] mode_wdata, // Value written
  input wire logic sw_clear, // Software clear command
  input wire logic ev_valid, // Enabled conversion result for this channel
  input wire bac_pkg::bac_src_t ev_src, // Which quantity was converted
  input wire logic ev_alarm, // Conversion shows an alarm condition
  output logic [1:0] mode, // Current clamp-mode field
  output logic clamp, // Gate held at external clamp voltage
  output logic flag_set // One-cycle alarm flag set pulse
);

  logic [1:0] next_mode;
  logic next_clamp;
  logic next_flag;
  logic [1:0] cur;

  always_comb begin
    next_mode = mode;
    next_clamp = clamp;
    next_flag = 1'b0;
    cur = mode;
    if (mode_wr) begin
      // New mode takes effect at once
      cur = mode_wdata; // see R20
      next_mode = mode_wdata;
      next_clamp = (mode_wdata == bac_pkg::CLAMP_FORCE); // see R03
    end else if (sw_clear && mode == bac_pkg::CLAMP_FORCE) begin
      next_clamp = 1'b0; // see R03
    end
    // Evaluated after the write so a hardware-forced 00 wins a same-cycle write
    if (ev_valid) begin
      next_flag = ev_alarm; // see R04
      case (bac_pkg::bac_clamp_mode_t'(cur))
        bac_pkg::CLAMP_FORCE: begin
        end
        bac_pkg::CLAMP_FLAG: begin
          next_clamp = 1'b0; // see R04
        end
        bac_pkg::CLAMP_AUTO: begin
          if (ev_alarm) begin
            next_clamp = 1'b1; // see R05
            // Clamping the gate would clear its own alarm, so latch it instead
            if (ev_src == bac_pkg::SRC_GATE) begin
              next_mode = bac_pkg::CLAMP_FORCE; // see R06
            end
          end else if (ev_src != bac_pkg::SRC_GATE) begin
            next_clamp = 1'b0; // see R05
          end
        end
        bac_pkg::CLAMP_SEMI: begin
          if (ev_alarm) begin
            next_clamp = 1'b1; // see R07
            next_mode = bac_pkg::CLAMP_FORCE; // see R07
          end
        end
        default: begin
        end
      endcase
      // A latch owed under the old mode beats a same-cycle host write
      if (ev_alarm && (mode == bac_pkg::CLAMP_SEMI
          || (mode == bac_pkg::CLAMP_AUTO && ev_src == bac_pkg::SRC_GATE))) begin
        next_mode = bac_pkg::CLAMP_FORCE; // see R07 R20
        next_clamp = 1'b1; // see R07 R20
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode <= bac_pkg::CLAMP_FORCE;
      clamp <= 1'b1;
      flag_set <= 1'b0;
    end else begin
      mode <= next_mode;
      clamp <= next_clamp;
      flag_set <= next_flag;
    end
  end

  chk_flag_never_clamps: assert property (@(posedge clk) disable iff (!rst_n) // see R04
    (mode == bac_pkg::CLAMP_FLAG && !mode_wr) |=> !clamp)
    else $error("clamp asserted in flag-only mode");

  chk_semi_latch: assert property (@(posedge clk) disable iff (!rst_n) // see R07
    (mode == bac_pkg::CLAMP_SEMI && !mode_wr && ev_valid && ev_alarm)
    |=> (clamp && mode == bac_pkg::CLAMP_FORCE) ##1 clamp)
    else $error("semi-automatic alarm did not latch the clamp");

  chk_auto_release: assert property (@(posedge clk) disable iff (!rst_n) // see R05
    (mode == bac_pkg::CLAMP_AUTO && !mode_wr && ev_valid && !ev_alarm
     && ev_src != bac_pkg::SRC_GATE) |=> !clamp && flag_set == 1'b0)
    else $error("automatic clamp not released on clear conversion");

  chk_auto_gate: assert property (@(posedge clk) disable iff (!rst_n) // see R06
    (mode == bac_pkg::CLAMP_AUTO && !mode_wr && ev_valid && ev_alarm
     && ev_src == bac_pkg::SRC_GATE) |=> clamp && flag_set && mode == bac_pkg::CLAMP_FORCE)
    else $error("gate alarm in automatic mode did not latch");

  chk_force_hold: assert property (@(posedge clk) disable iff (!rst_n) // see R03
    (mode_wr && mode_wdata == bac_pkg::CLAMP_FORCE) |=> clamp)
    else $error("mode 00 write did not clamp");

endmodule

`default_nettype wire

// ### bac_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module bac_host_model (
  input wire logic clk, // System clock
  output var bac_pkg::bac_cmd_t cmd, // Command towards the device
  input wire logic rsp_valid, // Read answer strobe
  input wire logic [15:0] rsp_data // Read answer word
);
  initial begin
    cmd = '{1'b0, 8'h00, 16'h0000};
  end

  // One command per call; released data shows the inverse so a stale word never matches
  task automatic xfer(input logic [7:0] code, input logic [15:0] data,
                      output logic [15:0] rdata, output logic got);
    int i;
    got = 1'b1;
    rdata = 16'h0000;
    @(posedge clk);
    cmd <= '{1'b1, code, data};
    @(posedge clk);
    cmd <= '{1'b0, code, ~data};
    #1;
    if (code == bac_pkg::CMD_SRC_RD || code == bac_pkg::CMD_OUT_RD) begin
      got = 1'b0;
      i = 0;
      while (i < 4 && !got) begin
        if (rsp_valid === 1'b1) begin
          rdata = rsp_data;
          got = 1'b1;
        end else begin
          @(posedge clk);
          #1;
        end
        i++;
      end
    end
  endtask
endmodule

`default_nettype wire

// ### tb_bac_alarm_cfg.sv
`timescale 1ns/1ps
`default_nettype none

module tb_bac_alarm_cfg;
  typedef struct {
    logic [7:0] wc;
    logic [15:0] wd;
    logic [15:0] rd;
    logic [7:0] gh;
    logic [7:0] sh;
  } bac_row_t;

  logic clk;
  logic rstn;
  logic sw_clear;
  bac_pkg::bac_cmd_t cmd;
  bac_pkg::bac_conv_t conv;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic [11:0] src_cfg;
  logic [7:0] gate_hyst_lsb;
  logic [7:0] st_hyst_lsb;
  logic [1:0] clamp;
  logic [1:0] alarm_flag_set;
  int miscompares = 0;
  int samples_checked = 0;

  // Output rows keep both clamp modes at 01 so the hysteresis sweep never clamps
  bac_row_t rows [7] = '{
    '{8'h3c, 16'h00d4, 16'h00d4, 8'h08, 8'h40},
    '{8'h3c, 16'hf194, 16'h0194, 8'h10, 8'h20},
    '{8'h3c, 16'h0254, 16'h0254, 8'h20, 8'h10},
    '{8'h3c, 16'h0f17, 16'h0f17, 8'h40, 8'h08},
    '{8'h3e, 16'hffff, 16'h0fff, 8'h40, 8'h08},
    '{8'h3e, 16'ha5a5, 16'h05a5, 8'h40, 8'h08},
    '{8'h3e, 16'h5a5a, 16'h0a5a, 8'h40, 8'h08}};

  bac_alarm_cfg #(.NUM_CH(2)) i_bac_alarm_cfg (.clk(clk), .rstn(rstn), .cmd(cmd),
    .sw_clear(sw_clear), .conv(conv), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .src_cfg(src_cfg), .gate_hyst_lsb(gate_hyst_lsb), .st_hyst_lsb(st_hyst_lsb),
    .clamp(clamp), .alarm_flag_set(alarm_flag_set));

  bac_host_model i_bac_host_model (.clk(clk), .cmd(cmd), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    $display("Checks made: %0d, mismatches: %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [7:0] c, input logic [15:0] d, input logic [15:0] exp);
    logic [15:0] r;
    logic got;
    i_bac_host_model.xfer(c, d, r, got);
    if (got !== 1'b1) begin
      miscompares++;
      results();
    end else if (c[7]) begin
      chk(r, exp);
    end
  endtask

  task automatic ev(input logic ch, input bac_pkg::bac_src_t s, input logic a,
                    input logic [1:0] ec, input logic [1:0] ef);
    @(posedge clk);
    conv <= '{1'b1, ch, s, a};
    @(posedge clk);
    conv <= '{1'b0, ~ch, s, ~a};
    #1;
    chk({12'h000, clamp, alarm_flag_set}, {12'h000, ec, ef});
  endtask

  initial begin
    rstn = 1'b0;
    sw_clear = 1'b0;
    conv = '{1'b0, 1'b0, bac_pkg::SRC_SENSE, 1'b0};
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 7; k++) begin
      acc(rows[k].wc, rows[k].wd, 16'h0000);
      acc(rows[k].wc | 8'h80, 16'h0000, rows[k].rd);
      chk({gate_hyst_lsb, st_hyst_lsb}, {rows[k].gh, rows[k].sh});
      if (rows[k].wc == bac_pkg::CMD_SRC_WR) chk({4'h0, src_cfg}, rows[k].rd);
    end
    // Unknown code must leave the source word alone
    acc(8'h55, 16'h0000, 16'h0000);
    acc(bac_pkg::CMD_SRC_RD, 16'h0000, 16'h0a5a);
    ev(1'b0, bac_pkg::SRC_GATE, 1'b1, 2'b00, 2'b00);
    ev(1'b0, bac_pkg::SRC_SENSE, 1'b1, 2'b00, 2'b01);
    ev(1'b0, bac_pkg::SRC_TEMP, 1'b1, 2'b00, 2'b01);
    @(posedge clk);
    rstn <= 1'b0;
    @(posedge clk);
    #1;
    chk({14'h0000, clamp}, 16'h0003);
    chk({gate_hyst_lsb, st_hyst_lsb}, 16'h0808);
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    acc(bac_pkg::CMD_SRC_RD, 16'h0000, 16'h0000);
    acc(bac_pkg::CMD_OUT_RD, 16'h0000, 16'h0000);
    @(posedge clk);
    sw_clear <= 1'b1;
    @(posedge clk);
    sw_clear <= 1'b0;
    #1;
    chk({14'h0000, clamp}, 16'h0000);
    acc(bac_pkg::CMD_OUT_WR, 16'h0000, 16'h0000);
    chk({14'h0000, clamp}, 16'h0003);
    acc(bac_pkg::CMD_SRC_WR, 16'h0aaa, 16'h0000);
    acc(bac_pkg::CMD_OUT_WR, 16'h0024, 16'h0000);
    chk({14'h0000, clamp}, 16'h0000);
    ev(1'b0, bac_pkg::SRC_SENSE, 1'b1, 2'b00, 2'b01);
    ev(1'b1, bac_pkg::SRC_TEMP, 1'b1, 2'b10, 2'b10);
    ev(1'b1, bac_pkg::SRC_SENSE, 1'b0, 2'b00, 2'b00);
    ev(1'b1, bac_pkg::SRC_GATE, 1'b1, 2'b10, 2'b10);
    ev(1'b1, bac_pkg::SRC_TEMP, 1'b0, 2'b10, 2'b00);
    acc(bac_pkg::CMD_OUT_RD, 16'h0000, 16'h0004);
    acc(bac_pkg::CMD_OUT_WR, 16'h001c, 16'h0000);
    ev(1'b0, bac_pkg::SRC_TEMP, 1'b1, 2'b01, 2'b01);
    acc(bac_pkg::CMD_OUT_RD, 16'h0000, 16'h0010);
    ev(1'b0, bac_pkg::SRC_TEMP, 1'b0, 2'b01, 2'b00);
    results();
  end
endmodule

`default_nettype wire
